// File: hdl/ibst_pkg.sv
// constants shared by the instrument bus status and trigger block
package ibst_pkg;

   // ----------------------------------------------------------------
   // status byte layout
   // ----------------------------------------------------------------
   localparam int STAT_W = 8;
   localparam int BIT_SUB_DONE = 0;
   localparam int BIT_LIMIT = 1;
   localparam int BIT_SRQ_CMD = 2;
   localparam int BIT_POWER_ON = 3;
   localparam int BIT_READY = 4;
   localparam int BIT_ERROR = 5;
   localparam int BIT_SERVICE = 6;
   localparam int BIT_DATA_AVAIL = 7;

   // ----------------------------------------------------------------
   // reset values and masks
   // ----------------------------------------------------------------
   // power-on service request and the request summary are set after reset
   localparam logic [7:0] STAT_RESET = 8'h48;
   localparam logic [7:0] STAT_CLEAR = 8'h00;
   localparam logic [7:0] READY_MASK = 8'h10;
   // bits that a device clear may keep while their condition persists
   localparam logic [7:0] DCL_KEEP_MASK = 8'h70;

endpackage

// File: hdl/ibst_top.sv
// bus-side status byte, remote state and trigger control of the instrument
// ----------------------------------------------------------------
// Notes on behaviour
// - remote only after REN plus own listen address
// - serial poll returns whole status byte value
// - bits 0-3: done, limit, srq command, power-on
// - bits 4-7: ready, error, service, data available
// - poll with SRQ clears bits whose condition ended
// - poll without SRQ leaves status byte unchanged
// - serial poll shows true ready bit
// - status query response always shows ready clear
// - serial poll keeps output buffer data
// - status query response overwrites output buffer
// - armed trigger message fires once, then holds
// - unarmed trigger message is ignored
// - paused subprogram resumes, no measurement trigger
// - device clear clears status except bits 4-6 whose condition persists, flushes, aborts subprogram
// - after clear, triggering off until next device_command_i pulse
// ----------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none

module ibst_top (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // bus pin, asynchronous to sys_clk_i
   input wire logic ren_i,
   // decoded bus messages, one-cycle pulses from the acceptor
   input wire logic my_listen_addr_i,
   input wire logic go_to_local_i,
   input wire logic host_serial_poll_call_i,
   input wire logic group_trigger_i,
   input wire logic device_clear_i,
   // decoded device commands, one-cycle pulses from the parser
   input wire logic device_command_i,
   input wire logic status_query_command_i,
   input wire logic trigger_arm_command_i,
   input wire logic single_trigger_command_i,
   // instrument conditions from the processor side
   input wire logic sub_done_i,
   input wire logic limit_exceeded_i,
   input wire logic srq_command_done_i,
   input wire logic ready_i,
   input wire logic error_logged_i,
   input wire logic data_avail_i,
   input wire logic sub_paused_i,
   // outputs
   output logic remote_o,
   output logic srq_o,
   output logic [7:0] bus_status_byte_o,
   output logic poll_valid_o,
   output logic [7:0] poll_data_o,
   output logic query_valid_o,
   output logic [7:0] query_data_o,
   output logic obuf_load_o,
   output logic obuf_flush_o,
   output logic ibuf_flush_o,
   output logic sub_abort_o,
   output logic sub_resume_o,
   output logic trigger_o,
   output logic trig_armed_o,
   output logic trig_disabled_o
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic ren_meta;
   logic ren_sync;
   logic remote;
   logic [7:0] bus_status_byte;
   logic [7:0] next_status;
   logic [7:0] cond;
   logic [7:0] keep_cond;
   logic srq_poll;
   logic status_clear;
   logic trig_armed;
   logic trig_disabled;
   logic trig_fire;
   logic trig_resume;

   // ----------------------------------------------------------------
   // REN synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ren_meta <= 1'b0;
         ren_sync <= 1'b0;
      end else begin
         ren_meta <= ren_i;
         ren_sync <= ren_meta;
      end
   end

   // ----------------------------------------------------------------
   // remote state
   // ----------------------------------------------------------------
   // REN alone never leaves local; the listen address does the move
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         remote <= 1'b0;
      end else if (!ren_sync) begin
         remote <= 1'b0;
      end else if (my_listen_addr_i) begin
         remote <= 1'b1;
      end else if (go_to_local_i) begin
         remote <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         remote_o <= 1'b0;
      end else begin
         remote_o <= remote;
      end
   end

   // ----------------------------------------------------------------
   // status conditions
   // ----------------------------------------------------------------
   // event bits are present only in the cycle of their pulse
   always_comb begin
      cond = ibst_pkg::STAT_CLEAR;
      cond[ibst_pkg::BIT_SUB_DONE] = sub_done_i;
      cond[ibst_pkg::BIT_LIMIT] = limit_exceeded_i;
      cond[ibst_pkg::BIT_SRQ_CMD] = srq_command_done_i;
      cond[ibst_pkg::BIT_POWER_ON] = 1'b0;
      cond[ibst_pkg::BIT_READY] = ready_i;
      cond[ibst_pkg::BIT_ERROR] = error_logged_i;
      cond[ibst_pkg::BIT_DATA_AVAIL] = data_avail_i;
      // request summary: any event, or a logged error
      cond[ibst_pkg::BIT_SERVICE] = sub_done_i | limit_exceeded_i | srq_command_done_i
         | error_logged_i;
   end

   // a poll only clears while SRQ is out; otherwise it is read-only
   assign srq_poll = host_serial_poll_call_i & srq_o;
   assign status_clear = srq_poll | device_clear_i;

   // on device clear only the keep bits may survive by their condition
   assign keep_cond = device_clear_i ? (cond & ibst_pkg::DCL_KEEP_MASK) : cond;

   // ----------------------------------------------------------------
   // status byte, one flop per bit
   // ----------------------------------------------------------------
   // a condition present in a poll clear wins over it; on device clear only the keep bits do
   genvar gi;
   generate
      for (gi = 0; gi < ibst_pkg::STAT_W; gi = gi + 1) begin : g_stat
         always_comb begin
            if (status_clear) begin
               next_status[gi] = keep_cond[gi];
            end else begin
               next_status[gi] = bus_status_byte[gi] | cond[gi];
            end
         end

         always_ff @(posedge sys_clk_i) begin
            if (rst_i) begin
               bus_status_byte[gi] <= ibst_pkg::STAT_RESET[gi];
            end else begin
               bus_status_byte[gi] <= next_status[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         bus_status_byte_o <= ibst_pkg::STAT_RESET;
      end else begin
         bus_status_byte_o <= next_status;
      end
   end

   // SRQ tracks the service bit in the same cycle as the byte
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         srq_o <= ibst_pkg::STAT_RESET[ibst_pkg::BIT_SERVICE];
      end else begin
         srq_o <= next_status[ibst_pkg::BIT_SERVICE];
      end
   end

   // ----------------------------------------------------------------
   // serial poll answer
   // ----------------------------------------------------------------
   // the byte as it stood when the poll came, ready bit untouched
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         poll_valid_o <= 1'b0;
      end else begin
         poll_valid_o <= host_serial_poll_call_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         poll_data_o <= ibst_pkg::STAT_CLEAR;
      end else if (host_serial_poll_call_i) begin
         poll_data_o <= bus_status_byte;
      end
   end

   // ----------------------------------------------------------------
   // status query answer
   // ----------------------------------------------------------------
   // the query interrupts the processor, so it never looks ready
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         query_valid_o <= 1'b0;
      end else begin
         query_valid_o <= status_query_command_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         query_data_o <= ibst_pkg::STAT_CLEAR;
      end else if (status_query_command_i) begin
         query_data_o <= bus_status_byte & ~ibst_pkg::READY_MASK;
      end
   end

   // replaces whatever sits in the output buffer
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         obuf_load_o <= 1'b0;
      end else begin
         obuf_load_o <= status_query_command_i;
      end
   end

   // ----------------------------------------------------------------
   // device clear actions
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         obuf_flush_o <= 1'b0;
      end else begin
         obuf_flush_o <= device_clear_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ibuf_flush_o <= 1'b0;
      end else begin
         ibuf_flush_o <= device_clear_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         sub_abort_o <= 1'b0;
      end else begin
         sub_abort_o <= device_clear_i;
      end
   end

   // ----------------------------------------------------------------
   // trigger control
   // ----------------------------------------------------------------
   // a paused subprogram takes the trigger message as a resume only
   assign trig_resume = group_trigger_i & sub_paused_i & ~device_clear_i;
   assign trig_fire = ~device_clear_i & ~trig_disabled & ((group_trigger_i & ~sub_paused_i & trig_armed)
      | single_trigger_command_i);

   // the arm is consumed by the trigger it produces
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         trig_armed <= 1'b0;
      end else if (trigger_arm_command_i) begin
         trig_armed <= 1'b1;
      end else if (trig_fire & group_trigger_i) begin
         trig_armed <= 1'b0;
      end
   end

   // clear suspends triggering; the arm state is kept for the restore
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         trig_disabled <= 1'b0;
      end else if (device_clear_i) begin
         trig_disabled <= 1'b1;
      end else if (device_command_i) begin
         trig_disabled <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         trigger_o <= 1'b0;
      end else begin
         trigger_o <= trig_fire;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         sub_resume_o <= 1'b0;
      end else begin
         sub_resume_o <= trig_resume;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         trig_armed_o <= 1'b0;
      end else begin
         trig_armed_o <= trig_armed;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         trig_disabled_o <= 1'b0;
      end else begin
         trig_disabled_o <= trig_disabled;
      end
   end

endmodule

`default_nettype wire

// File: hdl/ibst_top_unused_none.sv
`timescale 1ns/1ns

// File: dv/ibst_top_properties.sv
// checker on the ports of the bus status and trigger block
`timescale 1ns/1ns
`default_nettype none
module ibst_chk (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic my_listen_addr_i,
   input wire logic host_serial_poll_call_i,
   input wire logic group_trigger_i,
   input wire logic device_clear_i,
   input wire logic device_command_i,
   input wire logic status_query_command_i,
   input wire logic single_trigger_command_i,
   input wire logic sub_paused_i,
   input wire logic sub_done_i,
   input wire logic limit_exceeded_i,
   input wire logic srq_command_done_i,
   input wire logic ready_i,
   input wire logic error_logged_i,
   input wire logic data_avail_i,
   input wire logic remote_o,
   input wire logic srq_o,
   input wire logic [7:0] bus_status_byte_o,
   input wire logic poll_valid_o,
   input wire logic [7:0] poll_data_o,
   input wire logic query_valid_o,
   input wire logic [7:0] query_data_o,
   input wire logic obuf_load_o,
   input wire logic obuf_flush_o,
   input wire logic ibuf_flush_o,
   input wire logic sub_abort_o,
   input wire logic sub_resume_o,
   input wire logic trigger_o,
   input wire logic trig_disabled_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   a_poll_answer: assert property (host_serial_poll_call_i |=> poll_valid_o && poll_data_o == $past(bus_status_byte_o))
      else $error("poll answer wrong");
   // with conditions quiet a poll under SRQ must leave an empty byte
   a_poll_srq_clear: assert property (host_serial_poll_call_i && srq_o && !device_clear_i
      && !(sub_done_i || limit_exceeded_i || srq_command_done_i || ready_i || error_logged_i || data_avail_i)
      |=> bus_status_byte_o == 8'h00)
      else $error("poll clear wrong");
   a_poll_no_drop: assert property (host_serial_poll_call_i && !srq_o && !device_clear_i |=> (~bus_status_byte_o & $past(bus_status_byte_o)) == 8'h00)
      else $error("status bit lost on poll");
   a_query_busy: assert property (status_query_command_i |=> query_valid_o && obuf_load_o && !query_data_o[4])
      else $error("query answer wrong");
   a_poll_no_load: assert property (host_serial_poll_call_i && !status_query_command_i |=> !obuf_load_o)
      else $error("poll touched output buffer");
   a_srq_follow: assert property (srq_o == bus_status_byte_o[6])
      else $error("srq differs from service bit");
   a_clear_effect: assert property (device_clear_i |=> obuf_flush_o && ibuf_flush_o && sub_abort_o && (bus_status_byte_o & 8'h8F) == 8'h00)
      else $error("device clear effect wrong");
   a_clear_disable: assert property (device_clear_i && !device_command_i |=> ##1 trig_disabled_o)
      else $error("triggering not disabled");
   a_paused_resume: assert property (group_trigger_i && sub_paused_i && !single_trigger_command_i |=> !trigger_o)
      else $error("trigger while paused");
   a_remote_cause: assert property ($rose(remote_o) |-> $past(my_listen_addr_i, 2))
      else $error("remote without listen address");
   c_poll_clear: cover property (host_serial_poll_call_i && srq_o);
   c_trigger: cover property (trigger_o);
   c_resume: cover property (sub_resume_o);
endmodule
`default_nettype wire

// File: dv/ibst_bus_ctl.sv
// bus controller model: REN line and one-cycle bus message pulses
`timescale 1ns/1ns
`default_nettype none
module ibst_bus_ctl (
   input wire logic clk_i,
   output logic ren_o,
   output logic [4:0] msg_o
);
   initial begin
      ren_o = 1'b0;
      msg_o = 5'h00;
   end
   task set_ren(input logic v);
      @(negedge clk_i);
      ren_o = v;
   endtask
   // k: 0 listen, 1 go-to-local, 2 poll, 3 group trigger, 4 clear
   task send(input int k);
      @(negedge clk_i);
      if (k == 0 && !ren_o) ren_o = 1'b1;
      msg_o = 5'h01 << k;
      @(negedge clk_i);
      msg_o = 5'h00;
   endtask
endmodule
`default_nettype wire

// File: dv/ibst_tb_top.sv
// self-checking bench of the bus status and trigger block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module ibst_tb_top;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   // 0 done, 1 limit, 2 srq cmd, 3 device cmd, 4 query, 5 arm, 6 single
   logic [6:0] tin = 7'h00;
   logic ready = 1'b0, err = 1'b0, avail = 1'b0, paused = 1'b0;
   logic ren, remote, srq, pv, qv, load, oflush, iflush, abort, resume, trig, armed, dis;
   logic [4:0] msg;
   logic [7:0] sbyte, pdata, qdata;
   int n_fail = 0, comparisons = 0, cycles = 0;
   always #2 sys_clk_i = ~sys_clk_i;
   ibst_bus_ctl u_ctl (.clk_i(sys_clk_i), .ren_o(ren), .msg_o(msg));
   ibst_top u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ren_i(ren), .my_listen_addr_i(msg[0]),
      .go_to_local_i(msg[1]), .host_serial_poll_call_i(msg[2]), .group_trigger_i(msg[3]),
      .device_clear_i(msg[4]), .device_command_i(tin[3]), .status_query_command_i(tin[4]),
      .trigger_arm_command_i(tin[5]), .single_trigger_command_i(tin[6]), .sub_done_i(tin[0]),
      .limit_exceeded_i(tin[1]), .srq_command_done_i(tin[2]), .ready_i(ready), .error_logged_i(err),
      .data_avail_i(avail), .sub_paused_i(paused), .remote_o(remote), .srq_o(srq),
      .bus_status_byte_o(sbyte), .poll_valid_o(pv), .poll_data_o(pdata), .query_valid_o(qv),
      .query_data_o(qdata), .obuf_load_o(load), .obuf_flush_o(oflush), .ibuf_flush_o(iflush),
      .sub_abort_o(abort), .sub_resume_o(resume), .trigger_o(trig), .trig_armed_o(armed),
      .trig_disabled_o(dis));
   task report_and_stop();
      if (n_fail == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task p(input int k);
      @(negedge sys_clk_i);
      tin = 7'h01 << k;
      @(negedge sys_clk_i);
      tin = 7'h00;
   endtask
   task idle(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask
   // run is about 70 cycles, so this only fires on a hang
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         report_and_stop();
      end
   end
   initial begin
      idle(16);
      rst_i = 1'b0;
      `CHK("byte reset", 8'h48, sbyte)
      `CHK("srq reset", 1'b1, srq)
      u_ctl.send(2);
      `CHK("poll data", 8'h48, pdata)
      `CHK("poll valid", 1'b1, pv)
      `CHK("byte cleared", 8'h00, sbyte)
      `CHK("srq low", 1'b0, srq)
      ready = 1'b1;
      err = 1'b1;
      avail = 1'b1;
      p(0);
      p(1);
      p(2);
      `CHK("byte all", 8'hF7, sbyte)
      err = 1'b0;
      u_ctl.send(2);
      `CHK("poll sum", 8'hF7, pdata)
      `CHK("byte kept", 8'h90, sbyte)
      u_ctl.send(2);
      `CHK("poll ready", 8'h90, pdata)
      `CHK("byte same", 8'h90, sbyte)
      `CHK("no load", 1'b0, load)
      p(4);
      `CHK("query data", 8'h80, qdata)
      `CHK("query valid", 1'b1, qv)
      `CHK("obuf load", 1'b1, load)
      // armed before the clear, so the restore below is visible
      p(5);
      u_ctl.send(4);
      `CHK("flushes", 3'h7, {oflush, iflush, abort})
      `CHK("clear byte", 8'h10, sbyte)
      idle(1);
      `CHK("trig off", 1'b1, dis)
      u_ctl.send(3);
      `CHK("trig disabled", 1'b0, trig)
      p(6);
      `CHK("single disabled", 1'b0, trig)
      p(3);
      idle(1);
      u_ctl.send(3);
      `CHK("trig restored", 1'b1, trig)
      u_ctl.send(3);
      `CHK("trig unarmed", 1'b0, trig)
      `CHK("arm used", 1'b0, armed)
      p(5);
      u_ctl.send(3);
      `CHK("armed trig", 1'b1, trig)
      u_ctl.send(3);
      `CHK("held trig", 1'b0, trig)
      p(5);
      paused = 1'b1;
      u_ctl.send(3);
      `CHK("resume", 2'h2, {resume, trig})
      `CHK("arm kept", 1'b1, armed)
      paused = 1'b0;
      p(6);
      `CHK("single trig", 1'b1, trig)
      u_ctl.set_ren(1'b1);
      idle(4);
      `CHK("ren alone", 1'b0, remote)
      u_ctl.send(0);
      idle(1);
      `CHK("remote", 1'b1, remote)
      u_ctl.send(1);
      idle(1);
      `CHK("local", 1'b0, remote)
      report_and_stop();
   end
endmodule
bind ibst_top ibst_chk u_chk (.sys_clk_i, .rst_i, .my_listen_addr_i, .host_serial_poll_call_i,
   .group_trigger_i, .device_clear_i, .device_command_i, .status_query_command_i,
   .single_trigger_command_i, .sub_paused_i, .sub_done_i, .limit_exceeded_i, .srq_command_done_i,
   .ready_i, .error_logged_i, .data_avail_i, .remote_o, .srq_o, .bus_status_byte_o, .poll_valid_o,
   .poll_data_o, .query_valid_o, .query_data_o, .obuf_load_o, .obuf_flush_o, .ibuf_flush_o,
   .sub_abort_o, .sub_resume_o, .trigger_o, .trig_disabled_o);
`default_nettype wire
